// >>> common/eqc_pkg.sv
package eqc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_MODE     = 8'h00;
  localparam logic [7:0] OFF_CLK      = 8'h04;
  localparam logic [7:0] OFF_CNT_LO   = 8'h08;
  localparam logic [7:0] OFF_CNT_HI   = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;
  // Mode register fields
  localparam int MODE_OP_LO  = 0;
  localparam int MODE_CNT_UP = 2;
  // Clock register fields
  localparam int CLK_RD_LO   = 0;
  localparam int CLK_GE_LO   = 2;
  localparam int CLK_NORMAL_GAIN_SEL    = 4;
  localparam int CLK_FR_LO   = 5;
  localparam int CLK_LEAK    = 7;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CLK_RST  = 8'h9A;
  // Gains
  localparam logic [2:0] GAIN_NORM_0 = 3'h2;
  localparam logic [2:0] GAIN_NORM_1 = 3'h1;
  localparam logic [2:0] GAIN_EXT_BASE = 3'h2;
  // Return delays in bits
  localparam logic [9:0] RET_DLY_BASE = 10'h040;

  typedef enum logic [1:0] {
    EQC_NORMAL = 2'b00,
    EQC_SEARCH = 2'b01,
    EQC_OFF    = 2'b10
  } eqc_op_t;

  typedef enum logic [0:0] {
    EQC_RANGE_NORM = 1'b0,
    EQC_RANGE_EXT  = 1'b1
  } eqc_range_t;
endpackage

// >>> rtl/eqc_top.sv
// How it works
// - Each aux envelope rising edge steps the counter by one, up or down, unless a counter byte write falls in the same cycle.
// - Mode field: 0 normal, 1 search, 2 and 3 off.
// - Normal mode: main and aux channels processed, aux envelope not.
// - Search mode: only the aux channel and aux envelope processed, main channel not.
// - Off mode: sleep and read sync flag held high.
// - Off mode: accesses to registers other than mode register ignored.
// - Leak bit enables the loop filter leakage term.
// - Pull range codes 0..3 give 8, 16, 22, 28 percent.
// - Pull range code 0 never enters extended range.
// - Normal gain bit: 0 gives gain 2, 1 gives gain 1.
// - Extended gain codes 0..3 give gains 2..5.
// - Return to normal after programmed count of in-range bit periods.
// - Return delay codes 0..3 give 64, 128, 256, 512 bits.
// - Envelope counter is 16 bits, accessed as low then high byte.
// - Flag raised when the envelope counter reaches zero.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module eqc_top
  import eqc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        aux_envelope,
  input  wire logic        bit_tick,
  input  wire logic        freq_in_range,
  output logic             read_sync_flag,
  output logic             eq_sleep,
  output logic             main_proc_en,
  output logic             aux_proc_en,
  output logic             aux_env_proc_en,
  output logic             loop_leak_on,
  output logic [1:0]       pull_range,
  output logic             ext_range,
  output logic [2:0]       pll_gain,
  output logic             irq
);
  import eqc_pkg::*;

  logic [7:0]  mode_r, mode_nxt;
  logic [7:0]  clk_r, clk_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [1:0]  stat_r, stat_nxt;
  logic [1:0]  mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0]  env_sync_r, env_sync_nxt;
  logic        rng_s1_r, rng_s2_r, tick_s1_r, tick_s2_r, tick_d_r;
  eqc_range_t  rng_r, rng_nxt;
  logic [9:0]  ret_cnt_r, ret_cnt_nxt;
  logic [9:0]  ret_limit;
  eqc_op_t     op;
  logic        wr_acc, rd_acc, blocked, env_rise, tick, cnt_write, zero_evt;

  // Mode decode
  // decode op mode
  always_comb begin
    case (mode_r[MODE_OP_LO +: 2])
      2'b00:   op = EQC_NORMAL;
      2'b01:   op = EQC_SEARCH;
      default: op = EQC_OFF;
    endcase
  end

  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign blocked = (op == EQC_OFF) && (paddr != OFF_MODE);
  assign pslverr = 1'b0;

  assign env_rise = env_sync_r[1] && !env_sync_r[2];
  assign tick     = tick_s2_r && !tick_d_r;
  assign cnt_write = wr_acc && !blocked && (paddr == OFF_CNT_LO || paddr == OFF_CNT_HI);

  always_comb begin
    env_sync_nxt = {env_sync_r[1:0], aux_envelope};
  end

  // Register file and counter
  always_comb begin
    mode_nxt = mode_r;
    clk_nxt  = clk_r;
    cnt_nxt  = cnt_r;
    mask_nxt = mask_r;
    zero_evt = 1'b0;
    if (env_rise) begin
      if (mode_r[MODE_CNT_UP]) begin
        cnt_nxt = cnt_r + 16'h0001;
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
      end
      zero_evt = (cnt_nxt == 16'h0000);
    end
    if (wr_acc && !blocked) begin
      case (paddr)
        OFF_MODE:     mode_nxt = pwdata[7:0];
        OFF_CLK:      clk_nxt  = pwdata[7:0];
        OFF_CNT_LO:   cnt_nxt  = {cnt_r[15:8], pwdata[7:0]};
        OFF_CNT_HI:   cnt_nxt  = {pwdata[7:0], cnt_r[7:0]};
        OFF_IRQ_MASK: mask_nxt = pwdata[1:0];
        default:      mask_nxt = mask_r;
      endcase
    end
    if (cnt_write) begin
      zero_evt = 1'b0;
    end
  end

  // Sticky status, set wins over clear
  always_comb begin
    stat_nxt = stat_r;
    if (wr_acc && !blocked && paddr == OFF_IRQ_STAT) begin
      stat_nxt = stat_r & ~pwdata[1:0];
    end
    if (zero_evt) begin
      stat_nxt[0] = 1'b1;
    end
    if (rng_r == EQC_RANGE_NORM && rng_nxt == EQC_RANGE_EXT) begin
      stat_nxt[1] = 1'b1;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (psel && !penable && !pwrite && !blocked) begin
      case (paddr)
        OFF_MODE:     rdata_nxt = {24'h000000, mode_r};
        OFF_CLK:      rdata_nxt = {24'h000000, clk_r};
        OFF_CNT_LO:   rdata_nxt = {24'h000000, cnt_r[7:0]};
        OFF_CNT_HI:   rdata_nxt = {24'h000000, cnt_r[15:8]};
        OFF_IRQ_STAT: rdata_nxt = {30'h0, stat_r};
        OFF_IRQ_MASK: rdata_nxt = {30'h0, mask_r};
        OFF_STATUS:   rdata_nxt = {29'h0, read_sync_flag, ext_range, cnt_r == 16'h0000};
        default:      rdata_nxt = 32'h0000_0000;
      endcase
    end else if (rd_acc) begin
      rdata_nxt = rdata_r;
    end
  end

  // Clock extraction range control
  // return delay select
  assign ret_limit = RET_DLY_BASE << clk_r[CLK_RD_LO +: 2];

  always_comb begin
    rng_nxt     = rng_r;
    ret_cnt_nxt = ret_cnt_r;
    if (clk_r[CLK_FR_LO +: 2] == 2'b00) begin
      rng_nxt     = EQC_RANGE_NORM;
      ret_cnt_nxt = 10'h000;
    end else if (tick) begin
      case (rng_r)
        EQC_RANGE_NORM: begin
          if (!rng_s2_r) begin
            rng_nxt     = EQC_RANGE_EXT;
            ret_cnt_nxt = 10'h000;
          end
        end
        EQC_RANGE_EXT: begin
          if (!rng_s2_r) begin
            ret_cnt_nxt = 10'h000;
          end else if (ret_cnt_r + 10'h001 >= ret_limit) begin
            rng_nxt     = EQC_RANGE_NORM;
            ret_cnt_nxt = 10'h000;
          end else begin
            ret_cnt_nxt = ret_cnt_r + 10'h001;
          end
        end
        default: rng_nxt = EQC_RANGE_NORM;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_r     <= MODE_RST;
      clk_r      <= CLK_RST;
      cnt_r      <= 16'h0000;
      stat_r     <= 2'h0;
      mask_r     <= 2'h0;
      rdata_r    <= 32'h0000_0000;
      env_sync_r <= 3'h0;
      rng_s1_r   <= 1'b1;
      rng_s2_r   <= 1'b1;
      tick_s1_r  <= 1'b0;
      tick_s2_r  <= 1'b0;
      tick_d_r   <= 1'b0;
      rng_r      <= EQC_RANGE_NORM;
      ret_cnt_r  <= 10'h000;
    end else begin
      mode_r     <= mode_nxt;
      clk_r      <= clk_nxt;
      cnt_r      <= cnt_nxt;
      stat_r     <= stat_nxt;
      mask_r     <= mask_nxt;
      rdata_r    <= rdata_nxt;
      env_sync_r <= env_sync_nxt;
      rng_s1_r   <= freq_in_range;
      rng_s2_r   <= rng_s1_r;
      tick_s1_r  <= bit_tick;
      tick_s2_r  <= tick_s1_r;
      tick_d_r   <= tick_s2_r;
      rng_r      <= rng_nxt;
      ret_cnt_r  <= ret_cnt_nxt;
    end
  end

  assign prdata = rdata_r;
  assign irq    = |(stat_r & mask_r);

  assign main_proc_en    = (op == EQC_NORMAL);
  assign aux_proc_en     = (op != EQC_OFF);
  assign aux_env_proc_en = (op == EQC_SEARCH);
  assign eq_sleep        = (op == EQC_OFF);
  assign read_sync_flag  = (op == EQC_OFF);
  assign loop_leak_on    = clk_r[CLK_LEAK];
  assign pull_range      = clk_r[CLK_FR_LO +: 2];
  assign ext_range       = (rng_r == EQC_RANGE_EXT);

  always_comb begin
    if (rng_r == EQC_RANGE_EXT) begin
      pll_gain = GAIN_EXT_BASE + {1'b0, clk_r[CLK_GE_LO +: 2]};
    end else if (clk_r[CLK_NORMAL_GAIN_SEL]) begin
      pll_gain = GAIN_NORM_1;
    end else begin
      pll_gain = GAIN_NORM_0;
    end
  end

  AST_OFF_SYNC: assert property (@(posedge mclk) disable iff (srst)
    (mode_r[1] |-> read_sync_flag && eq_sleep && !aux_proc_en))
    else $error("off mode outputs wrong");
  AST_MODE_DEC: assert property (@(posedge mclk) disable iff (srst)
    (mode_r[1:0] == 2'b01) |-> (aux_proc_en && !main_proc_en))
    else $error("search decode wrong");
  AST_NORM_DEC: assert property (@(posedge mclk) disable iff (srst)
    (mode_r[1:0] == 2'b00) |-> (main_proc_en && aux_proc_en && !aux_env_proc_en))
    else $error("normal decode wrong");
  AST_OFF_BLOCK: assert property (@(posedge mclk) disable iff (srst)
    (psel && penable && pwrite && mode_r[1] && paddr == OFF_CLK) |=> $stable(clk_r))
    else $error("write accepted in off mode");
  AST_CNT_UP: assert property (@(posedge mclk) disable iff (srst)
    (env_rise && mode_r[2] && !cnt_write) |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("counter did not increment");
  AST_CNT_DN: assert property (@(posedge mclk) disable iff (srst)
    (env_rise && !mode_r[2] && !cnt_write) |=> cnt_r == $past(cnt_r) - 16'h0001)
    else $error("counter did not decrement");
  AST_ZERO_FLAG: assert property (@(posedge mclk) disable iff (srst)
    (zero_evt) |=> stat_r[0])
    else $error("zero flag not set");
  AST_FR0_NORM: assert property (@(posedge mclk) disable iff (srst)
    (clk_r[6:5] == 2'b00) |=> !ext_range)
    else $error("extended range with code 0");
  AST_GAIN_NORM: assert property (@(posedge mclk) disable iff (srst)
    (!ext_range) |-> pll_gain == (clk_r[4] ? 3'h1 : 3'h2))
    else $error("normal gain wrong");
  AST_ENTER_EXT: assert property (@(posedge mclk) disable iff (srst)
    (tick && !rng_s2_r && clk_r[6:5] != 2'b00 && clk_nxt[6:5] != 2'b00) |=> ext_range)
    else $error("extended range not entered");
  AST_IRQ: assert property (@(posedge mclk) disable iff (srst)
    irq == |(stat_r & mask_r))
    else $error("irq level wrong");
  AST_LEAK: assert property (@(posedge mclk) disable iff (srst)
    loop_leak_on == clk_r[7])
    else $error("leak output wrong");
  AST_PULL: assert property (@(posedge mclk) disable iff (srst)
    pull_range == clk_r[6:5])
    else $error("pull range output wrong");

  // Extended range gain for codes 0 to 2
  AST_GAIN_EXT0: assert property (@(posedge mclk) disable iff (srst)
    (ext_range && clk_r[3:2] == 2'b00) |-> pll_gain == 3'h2)
    else $error("extended gain code 0 wrong");
  AST_GAIN_EXT1: assert property (@(posedge mclk) disable iff (srst)
    (ext_range && clk_r[3:2] == 2'b01) |-> pll_gain == 3'h3)
    else $error("extended gain code 1 wrong");
  AST_GAIN_EXT2: assert property (@(posedge mclk) disable iff (srst)
    (ext_range && clk_r[3:2] == 2'b10) |-> pll_gain == 3'h4)
    else $error("extended gain code 2 wrong");

  // Return delay and entry flag
  AST_RET_HOLD: assert property (@(posedge mclk) disable iff (srst)
    (ext_range && tick && !rng_s2_r && clk_r[6:5] != 2'b00) |=> ext_range && ret_cnt_r == 10'h000)
    else $error("out of range bit did not restart return count");
  AST_RET_EXIT: assert property (@(posedge mclk) disable iff (srst)
    (ext_range && tick && rng_s2_r && clk_r[6:5] != 2'b00 && clk_r[1:0] == 2'b00
     && ret_cnt_r == 10'h03F) |=> !ext_range)
    else $error("no return after 64 bits");
  AST_EXT_FLAG: assert property (@(posedge mclk) disable iff (srst)
    (tick && !rng_s2_r && !ext_range && clk_r[6:5] != 2'b00) |=> stat_r[1])
    else $error("extended entry flag not set");

  // Register access checks
  AST_OFF_READ: assert property (@(posedge mclk) disable iff (srst)
    (psel && !penable && !pwrite && mode_r[1] && paddr != OFF_MODE) |=> prdata == 32'h0000_0000)
    else $error("read data returned in off mode");
  AST_OFF_MODE_WR: assert property (@(posedge mclk) disable iff (srst)
    (wr_acc && mode_r[1] && paddr == OFF_MODE) |=> mode_r == $past(pwdata[7:0]))
    else $error("mode write lost in off mode");
  AST_CNT_WR_LO: assert property (@(posedge mclk) disable iff (srst)
    (wr_acc && !blocked && paddr == OFF_CNT_LO) |=> cnt_r[7:0] == $past(pwdata[7:0]))
    else $error("counter low byte write lost");
  AST_CNT_WR_HI: assert property (@(posedge mclk) disable iff (srst)
    (wr_acc && !blocked && paddr == OFF_CNT_HI) |=> cnt_r[15:8] == $past(pwdata[7:0]))
    else $error("counter high byte write lost");
  AST_SET_WINS: assert property (@(posedge mclk) disable iff (srst)
    (zero_evt && wr_acc && !blocked && paddr == OFF_IRQ_STAT && pwdata[0]) |=> stat_r[0])
    else $error("zero flag clear beat the set");

  COV_OFF: cover property (@(posedge mclk) disable iff (srst) $rose(read_sync_flag));
  COV_SEARCH: cover property (@(posedge mclk) disable iff (srst) aux_env_proc_en);
  COV_RET_LONG: cover property (@(posedge mclk) disable iff (srst)
    ext_range && clk_r[1:0] == 2'b11 && ret_cnt_r == 10'h1FF);
  COV_EXT: cover property (@(posedge mclk) disable iff (srst) $fell(ext_range));
  COV_ZERO: cover property (@(posedge mclk) disable iff (srst) zero_evt);
endmodule
`default_nettype wire

// >>> tb/equalizer_clock_extraction_cfg_test.sv
`timescale 1ns/1ps
`default_nettype none
module equalizer_clock_extraction_cfg_test;
  import eqc_pkg::*;
  logic        mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic        aux_envelope = 0, bit_tick = 0, freq_in_range = 1;
  logic        pready, pslverr, read_sync_flag, eq_sleep, main_proc_en, aux_proc_en;
  logic        aux_env_proc_en, loop_leak_on, ext_range, irq;
  logic [1:0]  pull_range;
  logic [2:0]  pll_gain;
  int          error_cnt = 0, compares = 0, i, k;

  eqc_top dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .aux_envelope, .bit_tick, .freq_in_range, .read_sync_flag, .eq_sleep,
    .main_proc_en, .aux_proc_en, .aux_env_proc_en, .loop_leak_on, .pull_range, .ext_range,
    .pll_gain, .irq);

  always #5 mclk = ~mclk;

  task print_verdict;
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer, waits for pready under a bound
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      print_verdict();
    end
    rd = prdata;
    psel <= 0; penable <= 0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, e, what);
    chk(pslverr, 1'b0, "no error");
  endtask

  task settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task env;
    aux_envelope <= 1;
    repeat (5) @(posedge mclk);
    aux_envelope <= 0;
    repeat (5) @(posedge mclk);
  endtask

  // One bit period with the given in-range level
  task tick(input logic f);
    freq_in_range <= f;
    repeat (4) @(posedge mclk);
    bit_tick <= 1;
    repeat (4) @(posedge mclk);
    bit_tick <= 0;
    repeat (4) @(posedge mclk);
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    srst <= 0;
    rchk(OFF_MODE, 32'h00, "mode reset");
    rchk(OFF_CLK, 32'h9A, "clock reset");
    settle;
    chk({loop_leak_on, pull_range, pll_gain, ext_range}, 7'b1000010, "reset outs");
    for (i = 0; i < 4; i++) begin
      wr(OFF_MODE, i);
      settle;
      chk({eq_sleep, read_sync_flag, main_proc_en, aux_proc_en},
          (i == 0) ? 4'b0011 : (i == 1) ? 4'b0001 : 4'b1100, "op mode");
      if (i == 0) chk(aux_env_proc_en, 1'b0, "env proc");
      if (i >= 2) begin
        rchk(OFF_CLK, 32'h0, "off read");
        wr(OFF_CLK, 32'h0);
        rchk(OFF_MODE, i, "mode readback");
      end
    end
    wr(OFF_MODE, 32'h0);
    rchk(OFF_CLK, 32'h9A, "off write kept out");
    for (i = 0; i < 4; i++) begin
      wr(OFF_CLK, (i << 5) | ((i & 1) << 7) | ((i >> 1) << 4));
      settle;
      chk(loop_leak_on, i & 1, "leak");
      chk(pull_range, i, "range");
      chk(pll_gain, (i >> 1) ? 3'h1 : 3'h2, "normal gain");
    end
    wr(OFF_CLK, 32'h0);
    tick(1'b0);
    tick(1'b0);
    chk(ext_range, 1'b0, "code 0 stays normal");
    wr(OFF_IRQ_STAT, 32'h3);
    wr(OFF_IRQ_MASK, 32'h2);
    for (i = 0; i < 4; i++) begin
      wr(OFF_CLK, 32'h20 | i);
      tick(1'b0);
      chk(ext_range, 1'b1, "enter ext");
      chk(irq, 1'b1, "ext irq");
      wr(OFF_IRQ_STAT, 32'h2);
      settle;
      chk(irq, 1'b0, "ext irq cleared");
      if (i == 0) begin
        rchk(OFF_STATUS, 32'h3, "status ext");
        for (k = 0; k < 3; k++) begin
          wr(OFF_CLK, 32'h20 | (k << 2));
          settle;
          chk(pll_gain, 3'h2 + k, "ext gain");
        end
        wr(OFF_CLK, 32'h20);
        for (k = 0; k < 5; k++) tick(1'b1);
        tick(1'b0);
      end
      for (k = 0; k < (64 << i) - 1; k++) tick(1'b1);
      chk(ext_range, 1'b1, "still ext");
      tick(1'b1);
      chk(ext_range, 1'b0, "return delay");
    end
    wr(OFF_IRQ_STAT, 32'h3);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_CNT_LO, 32'h2);
    wr(OFF_CNT_HI, 32'h0);
    env;
    rchk(OFF_CNT_LO, 32'h1, "count down");
    chk(irq, 1'b0, "no early irq");
    env;
    rchk(OFF_CNT_LO, 32'h0, "count zero");
    chk(irq, 1'b1, "zero irq");
    rchk(OFF_STATUS, 32'h1, "status zero");
    wr(OFF_IRQ_STAT, 32'h1);
    wr(OFF_IRQ_MASK, 32'h0);
    settle;
    chk(irq, 1'b0, "zero irq cleared");
    env;
    rchk(OFF_CNT_HI, 32'hFF, "wrap hi");
    wr(OFF_MODE, 32'h4);
    env;
    rchk(OFF_IRQ_STAT, 32'h1, "masked flag");
    chk(irq, 1'b0, "masked irq");
    wr(OFF_CNT_LO, 32'hFF);
    wr(OFF_CNT_HI, 32'h0);
    env;
    rchk(OFF_CNT_LO, 32'h0, "up lo");
    rchk(OFF_CNT_HI, 32'h1, "up hi");
    rchk(8'h1C, 32'h0, "unmapped");
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
